// ==== bench/beo_bridge_chk.sv ====
`timescale 1ns/100ps
`include "beo_map.vh"

module beo_bridge_chk (
   input wire        clk_sys,
   input wire        sys_rst,
   input wire        clk_en,
   input wire [7:0]  avs_address,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0]  avs_byteenable,
   input wire        avs_waitrequest,
   input wire        dn_valid,
   input wire [31:0] dn_addr,
   input wire [1:0]  dn_size,
   input wire [63:0] dn_data,
   input wire        dn_cfg_addr,
   input wire        dn_pci_valid_q,
   input wire [31:0] dn_pci_addr_q,
   input wire [63:0] dn_pci_data_q,
   input wire        up_out_ready,
   input wire        up_out_valid_q,
   input wire [31:0] up_out_addr_q,
   input wire [1:0]  up_out_size_q,
   input wire [63:0] up_out_data_q,
   input wire        rd_req,
   input wire        pci_fifo_empty,
   input wire        pci_post_pending,
   input wire        rd_go_q
);
   reg le_q;
   reg fl_q;

   function [63:0] sw(input [63:0] d);
      integer i;
      for (i = 0; i < 8; i++) sw[8*i+:8] = d[8*(7-i)+:8];
   endfunction

   function [31:0] xv(input [1:0] s);
      xv = (s == 2'h0) ? 32'h7 : (s == 2'h1) ? 32'h6 : (s == 2'h2) ? 32'h4 : 32'h0;
   endfunction

   // ----------------------------------------
   // Shadow of the mode bits
   // ----------------------------------------
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         le_q <= 1'h0;
         fl_q <= 1'h0;
      end else if (avs_write && !avs_waitrequest && avs_address == `BEO_OFS_CTRL && avs_byteenable[0]) begin
         le_q <= avs_writedata[0];
         fl_q <= avs_writedata[1];
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------
   // Properties
   // ----------------------------------------
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest && clk_en
      |=> !avs_waitrequest ##1 avs_waitrequest) else $error("register access not answered in one cycle");
   dn_pulse_a: assert property (dn_valid |=> dn_pci_valid_q) else $error("down beat not forwarded");
   be_swap_a: assert property (dn_valid && !le_q && !dn_cfg_addr |=>
      dn_pci_data_q == sw($past(dn_data)) && dn_pci_addr_q == $past(dn_addr)) else $error("big-endian swap wrong");
   le_addr_a: assert property (dn_valid && le_q |=> dn_pci_data_q == $past(dn_data) &&
      dn_pci_addr_q == ($past(dn_addr) ^ xv($past(dn_size)))) else $error("little-endian address wrong");
   cfg_keep_a: assert property (dn_valid && dn_cfg_addr |=> dn_pci_data_q == $past(dn_data))
      else $error("config address value altered");
   piece_align_a: assert property (up_out_valid_q |->
      (up_out_addr_q[2:0] & ((3'h1 << up_out_size_q) - 3'h1)) == 3'h0) else $error("piece not aligned");
   piece_hold_a: assert property (up_out_valid_q && !up_out_ready |=> up_out_valid_q &&
      $stable(up_out_addr_q) && $stable(up_out_data_q)) else $error("stalled piece changed");
   go_free_a: assert property (!fl_q && rd_req |=> rd_go_q) else $error("read held without flush");
   flush_hold_a: assert property (fl_q && (!pci_fifo_empty || pci_post_pending) |=> !rd_go_q)
      else $error("read passed pending writes");

   cover property (up_out_valid_q && !up_out_ready);
   cover property (fl_q && rd_go_q);
   cover property (dn_valid && le_q);
endmodule // beo_bridge_chk

bind beo_bridge beo_bridge_chk chk_u (.clk_sys, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_byteenable, .avs_waitrequest, .dn_valid, .dn_addr, .dn_size, .dn_data, .dn_cfg_addr,
   .dn_pci_valid_q, .dn_pci_addr_q, .dn_pci_data_q, .up_out_ready, .up_out_valid_q, .up_out_addr_q,
   .up_out_size_q, .up_out_data_q, .rd_req, .pci_fifo_empty, .pci_post_pending, .rd_go_q);

// ==== bench/beo_far_model.sv ====
`timescale 1ns/100ps

// ----------------------------------------
// Processor-side taker of aligned pieces
// ----------------------------------------
module beo_far_model (
   input  wire clk_sys,
   input  wire sys_rst,
   input  wire slow,
   input  wire up_out_valid_q,
   output reg  up_out_ready
);
   reg ph_q;

   // Slow mode stalls every other cycle, so held pieces are exercised.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ph_q         <= 1'h0;
         up_out_ready <= 1'h1;
      end else begin
         ph_q         <= ~ph_q;
         up_out_ready <= !slow || ph_q;
      end
   end
endmodule // beo_far_model

// ==== bench/testbench.sv ====
`timescale 1ns/100ps
`include "beo_map.vh"

module testbench;
   localparam [31:0] UA = 32'h20000040;
   localparam [63:0] UD = 64'h0123456789abcdef;
   reg clk_sys;
   reg sys_rst = 1'h1, clk_en = 1'h1, avs_read = 1'h0, avs_write = 1'h0, dn_valid = 1'h0, dn_cfg_addr = 1'h0;
   reg up_valid = 1'h0, up_iack = 1'h0, up_local = 1'h0, rd_req = 1'h0, pci_fifo_empty = 1'h1;
   reg pci_post_pending = 1'h0, slow = 1'h0;
   reg [7:0] avs_address = 8'h0, up_be = 8'h0;
   reg [3:0] avs_byteenable = 4'hf;
   reg [4:0] err_event = 5'h0;
   reg [1:0] dn_size = 2'h0, proc_err_mid = 2'h0, pci_err_mid = 2'h0;
   reg [31:0] avs_writedata = 32'h0, dn_addr = 32'h0, up_addr = 32'h0, proc_err_addr = 32'h0, pci_err_addr = 32'h0;
   reg [63:0] dn_data = 64'h0, up_data = 64'h0;
   wire avs_waitrequest, dn_pci_valid_q, up_ready_q, up_out_ready, up_out_valid_q, rd_go_q, err_int_q;
   wire [1:0] up_out_size_q;
   wire [2:0] mcheck_q;
   wire [31:0] avs_readdata, dn_pci_addr_q, up_out_addr_q;
   wire [63:0] dn_pci_data_q, up_out_data_q;
   logic [31:0] pa[4];
   logic [1:0] ps[4];
   logic [63:0] pd[4];
   int npc, cyc = 0, num_errors = 0, cmp_count = 0;

   beo_bridge dut_u (.clk_sys, .sys_rst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable, .avs_readdata, .avs_waitrequest, .dn_valid, .dn_addr, .dn_size, .dn_data, .dn_cfg_addr,
      .dn_pci_valid_q, .dn_pci_addr_q, .dn_pci_data_q, .up_valid, .up_addr, .up_be, .up_data, .up_iack,
      .up_local, .up_ready_q, .up_out_ready, .up_out_valid_q, .up_out_addr_q, .up_out_size_q, .up_out_data_q,
      .rd_req, .pci_fifo_empty, .pci_post_pending, .rd_go_q, .err_event, .proc_err_addr, .proc_err_mid,
      .pci_err_addr, .pci_err_mid, .mcheck_q, .err_int_q);
   beo_far_model far_u (.clk_sys, .sys_rst, .slow, .up_out_valid_q, .up_out_ready);

   initial begin
      clk_sys = 1'h0;
      forever #4 clk_sys = ~clk_sys;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task results;
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         num_errors++;
         results;
      end
   end

   task chk(input [63:0] g, input [63:0] e);
      cmp_count++;
      if (g !== e) begin
         num_errors++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask

   function [63:0] sw(input [63:0] d);
      integer i;
      for (i = 0; i < 8; i++) sw[8*i+:8] = d[8*(7-i)+:8];
   endfunction

   // The request is held until waitrequest is seen low, then a spare edge
   // passes so the next access never reassigns a strobe in the same step.
   // Only the cycle ceiling ends an access that is never answered.
   task acc(input w, input [7:0] a, input [31:0] wd, output [31:0] d);
      avs_address <= a;
      avs_writedata <= wd;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'h0) begin
         @(posedge clk_sys);
      end
      d = avs_readdata;
      avs_write <= 1'h0;
      avs_read <= 1'h0;
      @(posedge clk_sys);
   endtask

   task wr(input [7:0] a, input [31:0] wd);
      logic [31:0] d;
      acc(1'h1, a, wd, d);
   endtask

   task rc(input [7:0] a, input [31:0] e);
      logic [31:0] d;
      acc(1'h0, a, 32'h0, d);
      chk(d, e);
   endtask

   task dn(input [31:0] a, input [1:0] s, input cfg);
      dn_addr <= a;
      dn_size <= s;
      dn_data <= UD;
      dn_cfg_addr <= cfg;
      dn_valid <= 1'h1;
      @(posedge clk_sys);
      dn_valid <= 1'h0;
      @(posedge clk_sys);
   endtask

   task up(input [7:0] be, input iack, input loc);
      npc = 0;
      up_addr <= UA;
      up_be <= be;
      up_data <= UD;
      up_iack <= iack;
      up_local <= loc;
      up_valid <= 1'h1;
      @(posedge clk_sys);
      while (up_ready_q !== 1'h1) begin
         @(posedge clk_sys);
      end
      up_valid <= 1'h0;
      repeat (20) begin
         @(posedge clk_sys);
         if (up_out_valid_q === 1'h1 && up_out_ready === 1'h1 && npc < 4) begin
            pa[npc] = up_out_addr_q;
            ps[npc] = up_out_size_q;
            pd[npc] = up_out_data_q;
            npc++;
         end
      end
   endtask

   task ev(input [4:0] e, input [1:0] mid);
      err_event <= e;
      proc_err_addr <= 32'hcafe0010;
      proc_err_mid <= mid;
      @(posedge clk_sys);
      err_event <= 5'h0;
      repeat (3) @(posedge clk_sys);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_regs;
      rc(`BEO_OFS_CTRL, 32'h0);
      rc(`BEO_OFS_ENABLE, 32'h0);
      rc(`BEO_OFS_STATUS, 32'h0);
      rc(`BEO_OFS_EATTR, 32'h3);
      wr(8'h40, 32'hffffffff);
      rc(8'h40, 32'h0);
      wr(`BEO_OFS_CTRL, 32'hffffffff);
      rc(`BEO_OFS_CTRL, 32'h3);
      wr(`BEO_OFS_ENABLE, 32'h00011f1f);
      rc(`BEO_OFS_ENABLE, 32'h00011f1f);
      wr(`BEO_OFS_CTRL, 32'h0);
   endtask

   task t_down;
      int s;
      dn(32'h80000cf8, 2'h2, 1'h0);
      chk(dn_pci_valid_q, 1'h1);
      chk(dn_pci_addr_q, 32'h80000cf8);
      chk(dn_pci_data_q, sw(UD));
      dn(32'h80000cf8, 2'h2, 1'h1);
      chk(dn_pci_data_q, UD);
      wr(`BEO_OFS_CTRL, 32'h1);
      for (s = 0; s < 4; s++) begin
         dn(32'h10000000, s[1:0], 1'h0);
         chk(dn_pci_addr_q, 32'h10000000 ^ (s == 0 ? 7 : s == 1 ? 6 : s == 2 ? 4 : 0));
         chk(dn_pci_data_q, UD);
      end
      dn(32'h80000cfc, 2'h2, 1'h1);
      chk(dn_pci_addr_q, 32'h80000cf8);
      chk(dn_pci_data_q, UD);
      wr(`BEO_OFS_CTRL, 32'h0);
   endtask

   task t_up;
      slow <= 1'h1;
      up(8'h0e, 1'h0, 1'h0);
      chk(npc, 2);
      chk({pa[0], 30'h0, ps[0]}, {UA | 32'h1, 32'h0});
      chk({pa[1], 30'h0, ps[1]}, {UA | 32'h2, 32'h1});
      chk(pd[0], sw(UD));
      slow <= 1'h0;
      up(8'hff, 1'h0, 1'h1);
      chk(pd[0], UD);
      wr(`BEO_OFS_CTRL, 32'h1);
      up(8'hff, 1'h0, 1'h0);
      chk({pa[0], 30'h0, ps[0]}, {UA, 32'h3});
      chk(pd[0], UD);
      up(8'h01, 1'h1, 1'h0);
      chk(npc, 1);
      chk(pa[0], UA);
      up(8'h01, 1'h0, 1'h0);
      chk(pa[0], UA ^ 32'h7);
      wr(`BEO_OFS_CTRL, 32'h0);
      up(8'h01, 1'h1, 1'h0);
      chk(pd[0], sw(UD));
   endtask

   task t_err;
      wr(`BEO_OFS_ENABLE, 32'h00001f1f);
      ev(5'h01, 2'h0);
      rc(`BEO_OFS_STATUS, 32'h1);
      rc(`BEO_OFS_EADDR, 32'hcafe0010);
      rc(`BEO_OFS_EATTR, 32'h100);
      chk(mcheck_q, 3'h1);
      chk(err_int_q, 1'h1);
      ev(5'h08, 2'h1);
      rc(`BEO_OFS_STATUS, 32'h81);
      rc(`BEO_OFS_EATTR, 32'h100);
      wr(`BEO_OFS_STATUS, 32'h0);
      rc(`BEO_OFS_STATUS, 32'h81);
      wr(`BEO_OFS_STATUS, 32'h81);
      rc(`BEO_OFS_STATUS, 32'h0);
      wr(`BEO_OFS_ENABLE, 32'h00010008);
      ev(5'h08, 2'h0);
      rc(`BEO_OFS_STATUS, 32'h8);
      rc(`BEO_OFS_EATTR, 32'h3);
      chk(mcheck_q, 3'h2);
      chk(err_int_q, 1'h0);
      wr(`BEO_OFS_STATUS, 32'h8);
   endtask

   task t_flush;
      pci_fifo_empty <= 1'h0;
      rd_req <= 1'h1;
      repeat (2) @(posedge clk_sys);
      chk(rd_go_q, 1'h1);
      rd_req <= 1'h0;
      wr(`BEO_OFS_CTRL, 32'h2);
      rd_req <= 1'h1;
      repeat (3) @(posedge clk_sys);
      chk(rd_go_q, 1'h0);
      pci_fifo_empty <= 1'h1;
      pci_post_pending <= 1'h1;
      repeat (3) @(posedge clk_sys);
      chk(rd_go_q, 1'h0);
      pci_post_pending <= 1'h0;
      repeat (3) @(posedge clk_sys);
      chk(rd_go_q, 1'h1);
      rd_req <= 1'h0;
   endtask

   initial begin
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'h0;
      @(posedge clk_sys);
      t_regs;
      t_down;
      t_up;
      t_err;
      t_flush;
      results;
   end
endmodule // testbench

// ==== logic/beo_bridge.v ====
`timescale 1ns/100ps
`include "beo_map.vh"

module beo_bridge #(
   parameter NSRC = `BEO_NUM_SRC
) (
   input  wire            clk_sys,
   input  wire            sys_rst,
   input  wire            clk_en,
   input  wire [7:0]      avs_address,
   input  wire            avs_read,
   input  wire            avs_write,
   input  wire [31:0]     avs_writedata,
   input  wire [3:0]      avs_byteenable,
   output reg  [31:0]     avs_readdata,
   output reg             avs_waitrequest,
   input  wire            dn_valid,
   input  wire [31:0]     dn_addr,
   input  wire [1:0]      dn_size,
   input  wire [63:0]     dn_data,
   input  wire            dn_cfg_addr,
   output reg             dn_pci_valid_q,
   output reg  [31:0]     dn_pci_addr_q,
   output reg  [63:0]     dn_pci_data_q,
   input  wire            up_valid,
   input  wire [31:0]     up_addr,
   input  wire [7:0]      up_be,
   input  wire [63:0]     up_data,
   input  wire            up_iack,
   input  wire            up_local,
   output reg             up_ready_q,
   input  wire            up_out_ready,
   output reg             up_out_valid_q,
   output reg  [31:0]     up_out_addr_q,
   output reg  [1:0]      up_out_size_q,
   output reg  [63:0]     up_out_data_q,
   input  wire            rd_req,
   input  wire            pci_fifo_empty,
   input  wire            pci_post_pending,
   output reg             rd_go_q,
   input  wire [NSRC-1:0] err_event,
   input  wire [31:0]     proc_err_addr,
   input  wire [1:0]      proc_err_mid,
   input  wire [31:0]     pci_err_addr,
   input  wire [1:0]      pci_err_mid,
   output reg  [2:0]      mcheck_q,
   output reg             err_int_q
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function [2:0] low_idx8;
      input [7:0] m;
      integer k;
      begin
         low_idx8 = 3'h0;
         for (k = 7; k >= 0; k = k - 1) begin
            if (m[k]) begin
               low_idx8 = k[2:0];
            end
         end
      end
   endfunction

   function [NSRC-1:0] low_one;
      input [NSRC-1:0] m;
      begin
         low_one = m & (~m + {{(NSRC-1){1'b0}}, 1'b1});
      end
   endfunction

   // Largest naturally aligned piece that starts at lane idx and is fully enabled.
   function [1:0] piece_size;
      input [7:0] m;
      input [2:0] idx;
      reg   [7:0] s;
      begin
         s = m >> idx;
         if (idx == 3'h0 && m == 8'hff) begin
            piece_size = `BEO_SZ_8B;
         end else if (idx[1:0] == 2'h0 && s[3:0] == 4'hf) begin
            piece_size = `BEO_SZ_4B;
         end else if (!idx[0] && s[1:0] == 2'h3) begin
            piece_size = `BEO_SZ_2B;
         end else begin
            piece_size = `BEO_SZ_1B;
         end
      end
   endfunction

   function [7:0] size_mask;
      input [1:0] sz;
      begin
         case (sz)
            `BEO_SZ_1B: size_mask = 8'h01;
            `BEO_SZ_2B: size_mask = 8'h03;
            `BEO_SZ_4B: size_mask = 8'h0f;
            default:    size_mask = 8'hff;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Register slave
   // ----------------------------------------------------------------
   reg  [1:0]      ctrl_q;
   reg  [16:0]     enable_q;
   reg  [NSRC-1:0] flags_q;
   reg             ovf_q;
   reg  [31:0]     eaddr_q;
   reg  [1:0]      emid_q;
   reg             evalid_q;
   reg  [1:0]      target_q;

   wire        le_mode   = ctrl_q[`BEO_CTRL_LE];
   wire        flush_on  = ctrl_q[`BEO_CTRL_FLUSH];
   wire        acc       = avs_read | avs_write;
   wire        done      = acc & ~avs_waitrequest;
   wire        wr_done   = done & avs_write;
   wire [31:0] be_mask   = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                            {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   wire [31:0] wr_bits   = avs_writedata & be_mask;

   reg [31:0] rd_mux;

   // Registers sit on the processor side only and are never byte-swapped.
   always @* begin
      case (avs_address)
         `BEO_OFS_CTRL:   rd_mux = {30'h0, ctrl_q};
         `BEO_OFS_ENABLE: rd_mux = {15'h0, enable_q};
         `BEO_OFS_STATUS: rd_mux = {24'h0, ovf_q, {(7-NSRC){1'b0}}, flags_q};
         `BEO_OFS_EADDR:  rd_mux = eaddr_q;
         `BEO_OFS_EATTR:  rd_mux = {23'h0, evalid_q, 6'h0, emid_q};
         default:         rd_mux = 32'h0;
      endcase
   end

   // One wait state per access: the answer stands in the cycle after the request is seen.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         avs_waitrequest <= 1'b1;
         avs_readdata    <= 32'h0;
      end else if (clk_en) begin
         if (acc && avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : 32'h0;
         end else begin
            avs_waitrequest <= 1'b1;
         end
      end
   end

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ctrl_q   <= `BEO_RST_CTRL;
         enable_q <= `BEO_RST_ENABLE;
      end else if (clk_en && wr_done) begin
         if (avs_address == `BEO_OFS_CTRL) begin
            ctrl_q <= (ctrl_q & ~be_mask[1:0]) | wr_bits[1:0];
         end
         if (avs_address == `BEO_OFS_ENABLE) begin
            enable_q <= (enable_q & ~be_mask[16:0]) | wr_bits[16:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Error capture
   // ----------------------------------------------------------------
   wire            st_wr    = wr_done && (avs_address == `BEO_OFS_STATUS);
   wire [NSRC-1:0] clr_f    = st_wr ? wr_bits[NSRC-1:0] : {NSRC{1'b0}};
   wire            clr_o    = st_wr & wr_bits[`BEO_ST_OVF];
   wire [NSRC-1:0] kept     = flags_q & ~clr_f;
   wire            any_err  = |err_event;
   wire [NSRC-1:0] first    = low_one(err_event);
   wire            multi    = |(err_event & ~first);
   wire            take_new = any_err && !(|kept);
   wire [1:0]      src_mid  = first[0] ? proc_err_mid : pci_err_mid;
   wire            src_ok   = |first[2:0];
   wire            default_check_target     = enable_q[`BEO_EN_DEFAULT_CHECK_TARGET];

   // An error in the same cycle as a clear is kept: the clear is applied first.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         flags_q  <= {NSRC{1'b0}};
         ovf_q    <= 1'b0;
         eaddr_q  <= 32'h0;
         emid_q   <= `BEO_MID_NONE;
         evalid_q <= 1'b0;
         target_q <= 2'h0;
      end else if (clk_en) begin
         if (take_new) begin
            flags_q <= first;
         end else begin
            flags_q <= kept;
         end
         ovf_q <= (ovf_q & ~clr_o) | (any_err & (|kept)) | (take_new & multi);
         if (take_new) begin
            if (first[0]) begin
               eaddr_q <= proc_err_addr;
            end else if (src_ok) begin
               eaddr_q <= pci_err_addr;
            end else begin
               eaddr_q <= 32'h0;
            end
            emid_q   <= src_ok ? src_mid : `BEO_MID_NONE;
            evalid_q <= src_ok;
            if (src_ok && src_mid != `BEO_MID_NONE) begin
               target_q <= src_mid;
            end else begin
               target_q <= {1'b0, default_check_target};
            end
         end
      end
   end

   wire [NSRC-1:0] mc_en  = enable_q[`BEO_EN_MC_LSB +: NSRC];
   wire [NSRC-1:0] int_en = enable_q[`BEO_EN_INT_LSB +: NSRC];

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         mcheck_q  <= 3'h0;
         err_int_q <= 1'b0;
      end else if (clk_en) begin
         if (|(flags_q & mc_en)) begin
            mcheck_q <= 3'h1 << target_q;
         end else begin
            mcheck_q <= 3'h0;
         end
         err_int_q <= |(flags_q & int_en);
      end
   end

   // ----------------------------------------------------------------
   // Processor to PCI path
   // ----------------------------------------------------------------
   wire [2:0]  dn_alo;
   wire [63:0] dn_dout;

   // The config-address register value is carried untouched.
   beo_endian_xlate u_dn_xlate (
      .le_mode  (le_mode),
      .no_swap  (dn_cfg_addr),
      .no_amod  (1'b0),
      .size     (dn_size),
      .addr_in  (dn_addr[2:0]),
      .data_in  (dn_data),
      .addr_out (dn_alo),
      .data_out (dn_dout)
   );

   // Processor masters must issue aligned 1/2/4/8 byte transfers in little-endian.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         dn_pci_valid_q <= 1'b0;
         dn_pci_addr_q  <= 32'h0;
         dn_pci_data_q  <= 64'h0;
      end else if (clk_en) begin
         dn_pci_valid_q <= dn_valid;
         if (dn_valid) begin
            dn_pci_addr_q <= {dn_addr[31:3], dn_alo};
            dn_pci_data_q <= dn_dout;
         end
      end
   end

   // ----------------------------------------------------------------
   // PCI to processor path with aligned splitting
   // ----------------------------------------------------------------
   localparam S_IDLE  = 2'b01;
   localparam S_SPLIT = 2'b10;

   reg  [1:0]  state_q;
   reg  [7:0]  mask_q;
   reg  [28:0] base_q;
   reg  [63:0] data_q;
   reg         iack_q;
   reg         local_q;

   wire [2:0]  p_idx   = low_idx8(mask_q);
   wire [1:0]  p_sz    = piece_size(mask_q, p_idx);
   wire [7:0]  p_bits  = size_mask(p_sz) << p_idx;
   wire [7:0]  mask_nx = mask_q & ~p_bits;
   wire        can_out = !up_out_valid_q || up_out_ready;
   wire [2:0]  up_alo;
   wire [63:0] up_dout;

   // Interrupt-acknowledge data is swapped in big-endian mode only; its address is left alone.
   beo_endian_xlate u_up_xlate (
      .le_mode  (le_mode),
      .no_swap  (local_q),
      .no_amod  (iack_q),
      .size     (p_sz),
      .addr_in  (p_idx),
      .data_in  (data_q),
      .addr_out (up_alo),
      .data_out (up_dout)
   );

   // Each piece is emitted once the output stage is free; the sender stalls meanwhile.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         state_q        <= S_IDLE;
         mask_q         <= 8'h0;
         base_q         <= 29'h0;
         data_q         <= 64'h0;
         iack_q         <= 1'b0;
         local_q        <= 1'b0;
         up_ready_q     <= 1'b1;
         up_out_valid_q <= 1'b0;
         up_out_addr_q  <= 32'h0;
         up_out_size_q  <= `BEO_SZ_1B;
         up_out_data_q  <= 64'h0;
      end else if (clk_en) begin
         if (up_out_valid_q && up_out_ready) begin
            up_out_valid_q <= 1'b0;
         end
         case (state_q)
            S_IDLE: begin
               if (up_valid && up_ready_q && up_be != 8'h0) begin
                  mask_q     <= up_be;
                  base_q     <= up_addr[31:3];
                  data_q     <= up_data;
                  iack_q     <= up_iack;
                  local_q    <= up_local;
                  up_ready_q <= 1'b0;
                  state_q    <= S_SPLIT;
               end
            end
            S_SPLIT: begin
               if (can_out) begin
                  up_out_valid_q <= 1'b1;
                  up_out_addr_q  <= {base_q, up_alo};
                  up_out_size_q  <= p_sz;
                  up_out_data_q  <= up_dout;
                  mask_q         <= mask_nx;
                  if (mask_nx == 8'h0) begin
                     up_ready_q <= 1'b1;
                     state_q    <= S_IDLE;
                  end
               end
            end
            default: begin
               state_q    <= S_IDLE;
               up_ready_q <= 1'b1;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read ordering
   // ----------------------------------------------------------------
   wire up_busy   = (state_q != S_IDLE) || up_out_valid_q;
   wire drained   = pci_fifo_empty && !pci_post_pending && !up_busy;

   // Grant is a level that follows the request, and with flush on it also waits until drained; it drops with the request.
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         rd_go_q <= 1'b0;
      end else if (clk_en) begin
         if (flush_on) begin
            rd_go_q <= rd_req && drained;
         end else begin
            rd_go_q <= rd_req;
         end
      end
   end

endmodule // beo_bridge

// ==== logic/beo_endian_xlate.v ====
`timescale 1ns/100ps
`include "beo_map.vh"

module beo_endian_xlate (
   input  wire        le_mode,
   input  wire        no_swap,
   input  wire        no_amod,
   input  wire [1:0]  size,
   input  wire [2:0]  addr_in,
   input  wire [63:0] data_in,
   output reg  [2:0]  addr_out,
   output reg  [63:0] data_out
);

   // ----------------------------------------------------------------
   // Address munge and lane reversal
   // ----------------------------------------------------------------
   function [2:0] amod_mask;
      input [1:0] sz;
      begin
         case (sz)
            `BEO_SZ_1B: amod_mask = 3'h7;
            `BEO_SZ_2B: amod_mask = 3'h6;
            `BEO_SZ_4B: amod_mask = 3'h4;
            default:    amod_mask = 3'h0;
         endcase
      end
   endfunction

   integer i;

   always @* begin
      addr_out = addr_in;
      data_out = data_in;
      if (le_mode && !no_amod) begin
         addr_out = addr_in ^ amod_mask(size);
      end
      if (!le_mode && !no_swap) begin
         for (i = 0; i < 8; i = i + 1) begin
            data_out[i*8 +: 8] = data_in[(7-i)*8 +: 8];
         end
      end
   end

endmodule // beo_endian_xlate

// ==== logic/beo_map.vh ====
`ifndef BEO_MAP_VH
`define BEO_MAP_VH

`define BEO_OFS_CTRL    8'h08
`define BEO_OFS_ENABLE  8'h20
`define BEO_OFS_STATUS  8'h24
`define BEO_OFS_EADDR   8'h28
`define BEO_OFS_EATTR   8'h2c

`define BEO_CTRL_LE     0
`define BEO_CTRL_FLUSH  1
`define BEO_EN_MC_LSB   0
`define BEO_EN_INT_LSB  8
`define BEO_EN_DEFAULT_CHECK_TARGET     16
`define BEO_ST_OVF      7
`define BEO_AT_VALID    8

`define BEO_RST_CTRL    2'h0
`define BEO_RST_ENABLE  17'h00000
`define BEO_NUM_SRC     5
`define BEO_MID_NONE    2'h3

`define BEO_SZ_1B       2'h0
`define BEO_SZ_2B       2'h1
`define BEO_SZ_4B       2'h2
`define BEO_SZ_8B       2'h3

`endif
